// >>> mbh_pkg.sv
`default_nettype none
package mbh_pkg;
   // ---------------------------------------------------------------
   // Multiplexed port: register numbers and fields
   // ---------------------------------------------------------------
   localparam logic [3:0] MBH_WR_CMD = 4'h0;
   localparam logic [3:0] MBH_WR_VECTOR = 4'h2;
   localparam logic [3:0] MBH_WR_SYNC = 4'h7;
   localparam logic [3:0] MBH_WR_MASTER = 4'h9;
   localparam logic [3:0] MBH_WR_CLKMODE = 4'hb;
   localparam logic [3:0] MBH_WR_EXTIRQ = 4'hf;
   localparam logic [3:0] MBH_RR_STATUS = 4'h0;
   localparam logic [3:0] MBH_RR_SPECIAL = 4'h1;
   localparam logic [3:0] MBH_RR_VECTOR = 4'h2;
   localparam logic [3:0] MBH_RR_PENDING = 4'h3;
   localparam logic [3:0] MBH_RR_RXDATA = 4'h8;
   localparam logic [3:0] MBH_RR_MISC = 4'ha;
   localparam logic [3:0] MBH_RR_BRG_LO = 4'hc;
   localparam logic [3:0] MBH_RR_BRG_HI = 4'hd;
   localparam logic [3:0] MBH_RR_EXTIRQ = 4'hf;
   localparam int MBH_CMD_SHIFT_EN = 1;
   localparam int MBH_CMD_SHIFT_DIR = 0;
   localparam int MBH_CMD_CODE_LSB = 3;
   localparam logic [2:0] MBH_CMD_RESET_IUS = 3'h7;
   localparam int MBH_CMD_CRC_LSB = 6;
   localparam int MBH_MASTER_VIS = 0;
   localparam int MBH_MASTER_MIE = 3;
   localparam int MBH_MASTER_RST_LSB = 6;
   localparam logic [1:0] MBH_RST_CHAN_B = 2'h1;
   localparam logic [1:0] MBH_RST_CHAN_A = 2'h2;
   localparam logic [1:0] MBH_RST_HW = 2'h3;
   localparam int MBH_EXT_PRIME_EN = 0;
   localparam int MBH_CLK_PIN_OE = 2;
   localparam int MBH_CLK_SRC_LSB = 0;
   localparam logic [7:0] MBH_REG_RESET = 8'h00;
   localparam logic [7:0] MBH_BUS_IDLE = 8'hff;
   // ---------------------------------------------------------------
   // Host controller: AXI4-Lite map and strobe timing
   // ---------------------------------------------------------------
   localparam logic [3:0] MBH_AXI_CMD = 4'h0;
   localparam logic [3:0] MBH_AXI_STATUS = 4'h4;
   localparam logic [3:0] MBH_AXI_CTRL = 4'h8;
   localparam logic [1:0] MBH_KIND_WRITE = 2'h0;
   localparam logic [1:0] MBH_KIND_READ = 2'h1;
   localparam logic [1:0] MBH_KIND_ACK = 2'h2;
   localparam logic [1:0] MBH_KIND_RESET = 2'h3;
   localparam logic [1:0] MBH_RESP_OKAY = 2'h0;
   localparam logic [1:0] MBH_RESP_SLVERR = 2'h2;
   localparam int MBH_PHASE_CYC = 3;
endpackage : mbh_pkg
`default_nettype wire

// >>> mbh_bus_if.sv
`timescale 1ns/100ps
`default_nettype none
interface mbh_bus_if;
   logic [7:0] ad_host_o;
   logic ad_host_oe;
   logic [7:0] ad_dev_o;
   logic ad_dev_oe;
   logic [7:0] muxed_addr_data_bus;
   logic addr_strobe_n;
   logic data_strobe_n;
   logic rd_wr;
   logic primary_select_n;
   logic secondary_select;
   logic irq_ack_strobe_n;
   logic chain_enable_in;
   logic chain_enable_out;
   logic irq_n_oe;
   logic irq_n;

   // Wire resolution; an undriven bus reads as pulled up
   assign muxed_addr_data_bus = ad_dev_oe ? ad_dev_o :
                                ad_host_oe ? ad_host_o : mbh_pkg::MBH_BUS_IDLE;
   assign irq_n = ~irq_n_oe;

   modport device (
      input muxed_addr_data_bus, addr_strobe_n, data_strobe_n, rd_wr,
      input primary_select_n, secondary_select, irq_ack_strobe_n,
      input chain_enable_in,
      output ad_dev_o, ad_dev_oe, chain_enable_out, irq_n_oe
   );
   modport host (
      input muxed_addr_data_bus, irq_n,
      output ad_host_o, ad_host_oe, addr_strobe_n, data_strobe_n, rd_wr,
      output primary_select_n, secondary_select, irq_ack_strobe_n,
      output chain_enable_in
   );
endinterface : mbh_bus_if
`default_nettype wire

// >>> mbh_device.sv
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Acknowledge claimed only while chain input high
// - Chain output low when servicing or acknowledging request
// - Open-drain interrupt pulled low while request pending
// - Acknowledge strobe sampled on rising master clock
// - Vector driven on read strobe of acknowledge
// - Vector may encode the pending interrupt type
// - Shared lines carry address first, then data
// - Address captured at address strobe rising edge
// - Primary select latched with address, else nothing
// - Host holds secondary select through whole transaction
// - Data strobe times transfer, read/write picks direction
// - Address and data strobes together mean reset
// - Everything but the chain output and clock pins synchronised to the master clock
// - Seventeen write and nine read registers
// - Prime register reachable only with enable bit
// - One vector register shared by both channels
// - Two channels with own registers; channel B reset clears only its clock mode and prime registers and its two pending bits
// - Command register: shift mode, CRC init, resets
// - Clock pin is input or programmed clock output
// - Shared reset and master-enable register
module mbh_device (
   input wire logic aclk,
   input wire logic aresetn,
   mbh_bus_if.device bus,
   input wire logic [3:0] irq_event,
   input wire logic [1:0][3:0][7:0] engine_status,
   input wire logic [1:0][3:0] chan_clock_sources,
   input wire logic chan_a_txrx_clock_pin_i,
   output logic chan_a_txrx_clock_pin_o,
   output logic chan_a_txrx_clock_pin_oe,
   input wire logic chan_b_txrx_clock_pin_i,
   output logic chan_b_txrx_clock_pin_o,
   output logic chan_b_txrx_clock_pin_oe,
   output logic [1:0] chan_pin_clock,
   output logic reg_wr_valid,
   output logic reg_wr_chan,
   output logic [4:0] reg_wr_index,
   output logic [7:0] reg_wr_data,
   output logic [1:0] crc_init,
   output logic [1:0] chan_reset,
   output logic hw_reset
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0][15:0][7:0] wr;
      logic [1:0][7:0] wr_prime;
      logic [7:0] addr;
      logic sel;
      logic shift_left;
      logic ds_q;
      logic [3:0] ip;
      logic [3:0] ius;
      logic [7:0] bus_out;
      logic bus_oe;
      logic wr_stb;
      logic wr_chan;
      logic [4:0] wr_idx;
      logic [7:0] wr_data;
      logic [1:0] crc_init;
      logic [1:0] chan_reset;
      logic hw_reset;
   } mbh_dev_state_t;

   mbh_dev_state_t s;
   mbh_dev_state_t next_s;

   // Channel A is index 1; shared registers live in slot 0
   function automatic logic [4:0] decode(input logic [7:0] a,
                                         input logic left);
      decode = left ? {a[0], a[4:1]} : {a[5], a[4:1]};
   endfunction : decode

   // Pending bits: 3 A receive, 2 A transmit, 1 B receive, 0 B transmit
   function automatic logic [1:0] highest(input logic [3:0] b);
      highest = b[3] ? 2'h3 : b[2] ? 2'h2 : b[1] ? 2'h1 : 2'h0;
   endfunction : highest

   logic mie;
   logic int_req;
   logic [1:0] hi;
   logic [7:0] vec_mod;
   logic ack_cycle;

   assign mie = s.wr[0][mbh_pkg::MBH_WR_MASTER][mbh_pkg::MBH_MASTER_MIE];
   // Any interrupt under service blocks new requests until released
   assign int_req = mie && (s.ip != 4'h0) && (s.ius == 4'h0);
   assign hi = highest(s.ip);
   assign vec_mod = {s.wr[0][mbh_pkg::MBH_WR_VECTOR][7:4], 1'b0, hi,
                     s.wr[0][mbh_pkg::MBH_WR_VECTOR][0]};
   assign ack_cycle = ~bus.irq_ack_strobe_n;

   function automatic logic [7:0] read_reg(input logic ch,
                                           input logic [3:0] idx,
                                           input mbh_dev_state_t st);
      logic [7:0] vis_vec;
      vis_vec = st.wr[0][mbh_pkg::MBH_WR_MASTER][mbh_pkg::MBH_MASTER_VIS]
                ? vec_mod : st.wr[0][mbh_pkg::MBH_WR_VECTOR];
      if (idx == mbh_pkg::MBH_RR_STATUS) begin
         read_reg = engine_status[ch][0];
      end else if (idx == mbh_pkg::MBH_RR_SPECIAL) begin
         read_reg = engine_status[ch][1];
      end else if (idx == mbh_pkg::MBH_RR_VECTOR) begin
         // Channel A shows the plain vector, channel B the coded one when VIS is set
         read_reg = ch ? st.wr[0][mbh_pkg::MBH_WR_VECTOR] : vis_vec;
      end else if (idx == mbh_pkg::MBH_RR_PENDING) begin
         read_reg = ch ? {4'h0, st.ip} : 8'h00;
      end else if (idx == mbh_pkg::MBH_RR_RXDATA) begin
         read_reg = engine_status[ch][2];
      end else if (idx == mbh_pkg::MBH_RR_MISC) begin
         read_reg = engine_status[ch][3];
      end else if (idx == mbh_pkg::MBH_RR_BRG_LO ||
                   idx == mbh_pkg::MBH_RR_BRG_HI ||
                   idx == mbh_pkg::MBH_RR_EXTIRQ) begin
         read_reg = st.wr[ch][idx];
      end else begin
         read_reg = 8'h00;
      end
   endfunction : read_reg

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [4:0] dec;
      logic ch;
      logic [3:0] idx;
      logic [7:0] d;
      logic ds_fall;
      logic ds_rise;
      logic [1:0] rst_code;
      dec = decode(s.addr, s.shift_left);
      ch = dec[4];
      idx = dec[3:0];
      d = bus.muxed_addr_data_bus;
      ds_fall = s.ds_q & ~bus.data_strobe_n;
      ds_rise = ~s.ds_q & bus.data_strobe_n;
      rst_code = d[mbh_pkg::MBH_MASTER_RST_LSB +: 2];
      next_s = s;
      next_s.ds_q = bus.data_strobe_n;
      next_s.wr_stb = 1'b0;
      next_s.crc_init = 2'b00;
      next_s.chan_reset = 2'b00;
      next_s.hw_reset = 1'b0;
      if (~bus.addr_strobe_n && ~bus.data_strobe_n) begin
         next_s.wr = '0;
         next_s.wr_prime = '0;
         next_s.ip = 4'h0;
         next_s.ius = 4'h0;
         next_s.sel = 1'b0;
         next_s.shift_left = 1'b0;
         next_s.bus_oe = 1'b0;
         next_s.hw_reset = 1'b1;
      end else begin
         // Value before the rise stands
         if (~bus.addr_strobe_n) begin
            next_s.addr = d;
            next_s.sel = ~bus.primary_select_n;
         end
         if (ds_fall && ack_cycle) begin
            if (bus.chain_enable_in && int_req) begin
               next_s.bus_out = read_reg(1'b0, mbh_pkg::MBH_RR_VECTOR, s);
               next_s.bus_oe = 1'b1;
               next_s.ius[hi] = 1'b1;
               next_s.ip[hi] = 1'b0;
            end
         end else if (ds_fall && s.sel && bus.secondary_select) begin
            if (bus.rd_wr) begin
               next_s.bus_out = read_reg(ch, idx, s);
               next_s.bus_oe = 1'b1;
            end else begin
               next_s.wr_stb = 1'b1;
               next_s.wr_chan = ch;
               next_s.wr_data = d;
               next_s.wr_idx = {1'b0, idx};
               if (idx == mbh_pkg::MBH_WR_SYNC &&
                   s.wr[ch][mbh_pkg::MBH_WR_EXTIRQ]
                   [mbh_pkg::MBH_EXT_PRIME_EN]) begin
                  next_s.wr_prime[ch] = d;
                  next_s.wr_idx = {1'b1, idx};
               end else if (idx == mbh_pkg::MBH_WR_VECTOR ||
                            idx == mbh_pkg::MBH_WR_MASTER) begin
                  next_s.wr[0][idx] = d;
               end else begin
                  next_s.wr[ch][idx] = d;
               end
               if (idx == mbh_pkg::MBH_WR_CMD) begin
                  if (d[mbh_pkg::MBH_CMD_SHIFT_EN]) begin
                     next_s.shift_left = ~d[mbh_pkg::MBH_CMD_SHIFT_DIR];
                  end
                  if (d[mbh_pkg::MBH_CMD_CODE_LSB +: 3] ==
                      mbh_pkg::MBH_CMD_RESET_IUS) begin
                     next_s.ius[highest(s.ius)] = 1'b0;
                  end
                  if (d[mbh_pkg::MBH_CMD_CRC_LSB +: 2] != 2'h0) begin
                     next_s.crc_init[ch] = 1'b1;
                  end
               end
               if (idx == mbh_pkg::MBH_WR_MASTER) begin
                  if (rst_code == mbh_pkg::MBH_RST_HW) begin
                     next_s.wr = '0;
                     next_s.wr_prime = '0;
                     next_s.ip = 4'h0;
                     next_s.ius = 4'h0;
                     next_s.shift_left = 1'b0;
                     next_s.hw_reset = 1'b1;
                  end else if (rst_code == mbh_pkg::MBH_RST_CHAN_A) begin
                     next_s.wr[1] = '0;
                     next_s.wr_prime[1] = mbh_pkg::MBH_REG_RESET;
                     next_s.ip[3:2] = 2'b00;
                     next_s.chan_reset[1] = 1'b1;
                  end else if (rst_code == mbh_pkg::MBH_RST_CHAN_B) begin
                     next_s.wr[0][mbh_pkg::MBH_WR_CLKMODE] =
                        mbh_pkg::MBH_REG_RESET;
                     next_s.wr_prime[0] = mbh_pkg::MBH_REG_RESET;
                     next_s.ip[1:0] = 2'b00;
                     next_s.chan_reset[0] = 1'b1;
                  end
               end
            end
         end
         // One data strobe per latched address; losing select aborts
         if (ds_rise || (~bus.secondary_select && ~ack_cycle)) begin
            next_s.bus_oe = 1'b0;
            if (ds_rise) begin
               next_s.sel = 1'b0;
            end
         end
      end
      // A new event beats any clear in the same cycle
      next_s.ip = next_s.ip | irq_event;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
         s.ds_q <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign bus.ad_dev_o = s.bus_out;
   assign bus.ad_dev_oe = s.bus_oe;
   assign bus.irq_n_oe = int_req;
   assign bus.chain_enable_out = bus.chain_enable_in && (s.ius == 4'h0) &&
                                 !(ack_cycle && int_req);
   assign reg_wr_valid = s.wr_stb;
   assign reg_wr_chan = s.wr_chan;
   assign reg_wr_index = s.wr_idx;
   assign reg_wr_data = s.wr_data;
   assign crc_init = s.crc_init;
   assign chan_reset = s.chan_reset;
   assign hw_reset = s.hw_reset;

   logic [1:0] pin_in;
   logic [1:0] pin_out;
   logic [1:0] pin_oe;
   assign pin_in = {chan_a_txrx_clock_pin_i, chan_b_txrx_clock_pin_i};
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_clk
         logic [7:0] mode;
         assign mode = s.wr[g][mbh_pkg::MBH_WR_CLKMODE];
         // Source order: oscillator, transmit, baud generator, DPLL
         assign pin_out[g] =
            chan_clock_sources[g][mode[mbh_pkg::MBH_CLK_SRC_LSB +: 2]];
         assign pin_oe[g] = mode[mbh_pkg::MBH_CLK_PIN_OE];
         assign chan_pin_clock[g] = pin_oe[g] ? 1'b0 : pin_in[g];
      end
   endgenerate
   assign chan_a_txrx_clock_pin_o = pin_out[1];
   assign chan_a_txrx_clock_pin_oe = pin_oe[1];
   assign chan_b_txrx_clock_pin_o = pin_out[0];
   assign chan_b_txrx_clock_pin_oe = pin_oe[0];
endmodule : mbh_device
`default_nettype wire

// >>> mbh_host.sv
`timescale 1ns/100ps
`default_nettype none
module mbh_host (
   input wire logic aclk,
   input wire logic aresetn,
   mbh_bus_if.host bus,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   typedef enum logic [2:0] {H_IDLE, H_ADDR, H_GAP, H_DATA, H_END}
      mbh_host_phase_t;
   typedef struct packed {
      mbh_host_phase_t ph;
      logic [7:0] cnt;
      logic [1:0] kind;
      logic [7:0] addr;
      logic [7:0] wdat;
      logic [7:0] rdat;
      logic chain;
      logic have_aw;
      logic have_w;
      logic [3:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } mbh_host_state_t;

   localparam logic [7:0] LAST = 8'(mbh_pkg::MBH_PHASE_CYC - 1);

   mbh_host_state_t s;
   mbh_host_state_t next_s;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic done;
      done = (s.cnt == LAST);
      next_s = s;
      next_s.cnt = done ? 8'h00 : s.cnt + 8'h01;
      case (s.ph)
         H_IDLE: next_s.cnt = 8'h00;
         H_ADDR: if (done) next_s.ph = H_GAP;
         H_GAP: if (done) next_s.ph = H_DATA;
         H_DATA: begin
            if (done) begin
               next_s.ph = H_END;
               next_s.rdat = bus.muxed_addr_data_bus;
            end
         end
         H_END: next_s.ph = H_IDLE;
         default: next_s.ph = H_IDLE;
      endcase
      // Write channel: address and data in either order
      if (s_axi_awvalid && s_axi_awready) begin
         next_s.have_aw = 1'b1;
         next_s.awaddr = s_axi_awaddr[3:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_s.have_w = 1'b1;
         next_s.wdata = s_axi_wdata;
         next_s.wstrb = s_axi_wstrb;
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      if (s.have_aw && s.have_w && !s.bvalid) begin
         next_s.have_aw = 1'b0;
         next_s.have_w = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = mbh_pkg::MBH_RESP_OKAY;
         if (s.awaddr == mbh_pkg::MBH_AXI_CMD) begin
            if (s.ph != H_IDLE || s.wstrb[2:0] != 3'h7) begin
               next_s.bresp = mbh_pkg::MBH_RESP_SLVERR;
            end else begin
               next_s.addr = s.wdata[7:0];
               next_s.wdat = s.wdata[15:8];
               next_s.kind = s.wdata[17:16];
               next_s.cnt = 8'h00;
               // An acknowledge carries no address phase
               next_s.ph = (s.wdata[17:16] == mbh_pkg::MBH_KIND_ACK)
                           ? H_GAP : H_ADDR;
            end
         end else if (s.awaddr == mbh_pkg::MBH_AXI_CTRL) begin
            if (s.wstrb[0]) begin
               next_s.chain = s.wdata[0];
            end
         end else begin
            next_s.bresp = mbh_pkg::MBH_RESP_SLVERR;
         end
      end
      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !s.rvalid) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = mbh_pkg::MBH_RESP_OKAY;
         next_s.rdata = 32'h0;
         if (s_axi_araddr[3:0] == mbh_pkg::MBH_AXI_STATUS) begin
            next_s.rdata = {16'h0, s.rdat, 6'h0, ~bus.irq_n,
                            s.ph != H_IDLE};
         end else if (s_axi_araddr[3:0] == mbh_pkg::MBH_AXI_CTRL) begin
            next_s.rdata = {31'h0, s.chain};
         end else if (s_axi_araddr[3:0] != mbh_pkg::MBH_AXI_CMD) begin
            next_s.rresp = mbh_pkg::MBH_RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
         s.ph <= H_IDLE;
         s.chain <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------------
   // Pins and bus handshakes
   // ---------------------------------------------------------------
   logic rst_cyc;
   logic ack_cyc;
   assign rst_cyc = (s.kind == mbh_pkg::MBH_KIND_RESET);
   assign ack_cyc = (s.kind == mbh_pkg::MBH_KIND_ACK);
   // Reset holds both strobes low together for the address phase
   assign bus.addr_strobe_n = !(s.ph == H_ADDR);
   assign bus.data_strobe_n = !(s.ph == H_DATA ||
                                (s.ph == H_ADDR && rst_cyc));
   assign bus.primary_select_n = !(s.ph == H_ADDR && !rst_cyc);
   assign bus.secondary_select = (s.ph != H_IDLE) && !rst_cyc &&
                                 !ack_cyc;
   assign bus.irq_ack_strobe_n = !(ack_cyc && s.ph != H_IDLE);
   assign bus.rd_wr = (s.kind != mbh_pkg::MBH_KIND_WRITE);
   assign bus.ad_host_o = (s.ph == H_ADDR) ? s.addr : s.wdat;
   assign bus.ad_host_oe = (s.ph == H_ADDR && !rst_cyc) ||
      (s.kind == mbh_pkg::MBH_KIND_WRITE &&
       (s.ph == H_GAP || s.ph == H_DATA));
   assign bus.chain_enable_in = s.chain;
   assign s_axi_awready = !s.have_aw && !s.bvalid;
   assign s_axi_wready = !s.have_w && !s.bvalid;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = !s.rvalid;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
endmodule : mbh_host
`default_nettype wire

// >>> mbh_chk.sv
`timescale 1ns/100ps
`default_nettype none
module mbh_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ad_host_oe,
   input wire logic ad_dev_oe,
   input wire logic addr_strobe_n,
   input wire logic data_strobe_n,
   input wire logic rd_wr,
   input wire logic secondary_select,
   input wire logic irq_ack_strobe_n,
   input wire logic chain_enable_in,
   input wire logic chain_enable_out,
   input wire logic irq_n_oe,
   input wire logic irq_n
);
   // ---------------------------------------------------------------
   // Wire-level properties
   // ---------------------------------------------------------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_chain;
      chain_enable_out |-> chain_enable_in && (irq_ack_strobe_n || irq_n);
   endproperty
   a_chain: assert property (p_chain) else $error("chain out high");
   property p_oe_cause; ad_dev_oe |-> $past(!data_strobe_n); endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("stray drive");
   property p_no_fight; ad_dev_oe |-> !ad_host_oe; endproperty
   a_no_fight: assert property (p_no_fight) else $error("bus fight");
   property p_rd;
      $fell(data_strobe_n) && rd_wr && secondary_select && addr_strobe_n
      |=> ad_dev_oe;
   endproperty
   a_rd: assert property (p_rd) else $error("read not driven");
   property p_wr; $fell(data_strobe_n) && !rd_wr |=> !ad_dev_oe; endproperty
   a_wr: assert property (p_wr) else $error("write drove bus");
   property p_ack;
      $fell(data_strobe_n) && !irq_ack_strobe_n && chain_enable_in && !irq_n
      |=> ad_dev_oe;
   endproperty
   a_ack: assert property (p_ack) else $error("no vector");
   property p_blk;
      $fell(data_strobe_n) && !irq_ack_strobe_n && !chain_enable_in
      |=> !ad_dev_oe;
   endproperty
   a_blk: assert property (p_blk) else $error("blocked ack drove");
   property p_rst; !addr_strobe_n && !data_strobe_n |-> ##[1:2] !irq_n_oe;
   endproperty
   a_rst: assert property (p_rst) else $error("irq after reset");
   c_ack: cover property ($fell(data_strobe_n) && !irq_ack_strobe_n);
   c_rst: cover property (!addr_strobe_n && !data_strobe_n);
   c_rd: cover property ($rose(ad_dev_oe));
endmodule : mbh_chk
`default_nettype wire

// >>> mbh_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
   errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module mbh_test;
   typedef struct packed {logic [1:0] k; logic [7:0] a, d, e;} mbh_row_t;
   localparam logic [1:0] kw = mbh_pkg::MBH_KIND_WRITE;
   localparam logic [1:0] kr = mbh_pkg::MBH_KIND_READ;
   localparam logic [1:0] ka = mbh_pkg::MBH_KIND_ACK;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [31:0] awaddr, wdata, araddr, rdata, st;
   logic [1:0] bresp, rresp, resp;
   logic [3:0] irq_event;
   int errors = 0;
   int checks_done = 0;
   mbh_row_t rows [9] = '{
      '{kw, 8'h38, 8'h5a, 8'h00}, '{kr, 8'h38, 8'h00, 8'h5a},
      '{kw, 8'h1a, 8'ha5, 8'h00}, '{kr, 8'h1a, 8'h00, 8'ha5},
      '{kw, 8'h04, 8'h3c, 8'h00}, '{kr, 8'h24, 8'h00, 8'h3c},
      '{kw, 8'h3e, 8'h01, 8'h00}, '{kr, 8'h3e, 8'h00, 8'h01},
      '{kr, 8'h18, 8'h00, 8'h00}};
   mbh_bus_if bus();
   mbh_device mbh_device_inst (.aclk(aclk), .aresetn(aresetn), .bus(bus),
      .irq_event(irq_event), .engine_status('0), .chan_clock_sources('0),
      .chan_a_txrx_clock_pin_i(1'b0), .chan_a_txrx_clock_pin_o(),
      .chan_a_txrx_clock_pin_oe(), .chan_b_txrx_clock_pin_i(1'b0),
      .chan_b_txrx_clock_pin_o(), .chan_b_txrx_clock_pin_oe(),
      .chan_pin_clock(), .reg_wr_valid(), .reg_wr_chan(), .reg_wr_index(),
      .reg_wr_data(), .crc_init(), .chan_reset(), .hw_reset());
   mbh_host mbh_host_inst (.aclk(aclk), .aresetn(aresetn), .bus(bus),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   mbh_chk mbh_chk_inst (.aclk(aclk), .aresetn(aresetn),
      .ad_host_oe(bus.ad_host_oe), .ad_dev_oe(bus.ad_dev_oe),
      .addr_strobe_n(bus.addr_strobe_n), .data_strobe_n(bus.data_strobe_n),
      .rd_wr(bus.rd_wr), .secondary_select(bus.secondary_select),
      .irq_ack_strobe_n(bus.irq_ack_strobe_n),
      .chain_enable_in(bus.chain_enable_in),
      .chain_enable_out(bus.chain_enable_out), .irq_n_oe(bus.irq_n_oe),
      .irq_n(bus.irq_n));
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic close_out(input bit hung);
      if (hung) errors++;
      if (errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   // ---------------------------------------------------------------
   // Register bus master
   // ---------------------------------------------------------------
   task automatic axw(input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      awaddr <= {28'h0, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 99; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (n == 99) close_out(1);
   endtask : axw
   task automatic axr(input logic [3:0] a, output logic [31:0] d);
      int n;
      @(posedge aclk);
      araddr <= {28'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 99; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
      if (n == 99) close_out(1);
   endtask : axr
   // Port cycle, then poll until idle
   task automatic op(input logic [1:0] k, input logic [7:0] a, d);
      int n;
      axw(mbh_pkg::MBH_AXI_CMD, {14'h0, k, d, a});
      for (n = 0; n < 50; n++) begin
         axr(mbh_pkg::MBH_AXI_STATUS, st);
         if (st[0] === 1'b0) break;
      end
      if (n == 50) close_out(1);
   endtask : op
   task automatic pulse_rx_a();
      @(posedge aclk);
      irq_event <= 4'h8;
      @(posedge aclk);
      irq_event <= 4'h0;
   endtask : pulse_rx_a
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, wdata, araddr, irq_event} = '0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      axr(mbh_pkg::MBH_AXI_CTRL, st);
      `CHK("ctrl", 32'h1, st)
      axr(4'hc, st);
      `CHK("unmapped", mbh_pkg::MBH_RESP_SLVERR, resp)
      foreach (rows[i]) begin
         op(rows[i].k, rows[i].a, rows[i].d);
         if (rows[i].k == kr) `CHK("rdata", rows[i].e, st[15:8])
      end
      op(kw, 8'h32, 8'h08);
      pulse_rx_a();
      axr(mbh_pkg::MBH_AXI_STATUS, st);
      `CHK("irq line", 1'b1, st[1])
      op(ka, 8'h00, 8'h00);
      `CHK("vector", 8'h3c, st[15:8])
      `CHK("chain busy", 1'b0, bus.chain_enable_out)
      axr(mbh_pkg::MBH_AXI_STATUS, st);
      `CHK("irq served", 1'b0, st[1])
      op(kw, 8'h20, 8'h38);
      `CHK("chain free", 1'b1, bus.chain_enable_out)
      // Upstream busy: the acknowledge must find nobody
      axw(mbh_pkg::MBH_AXI_CTRL, 32'h0);
      pulse_rx_a();
      op(ka, 8'h00, 8'h00);
      `CHK("blocked", mbh_pkg::MBH_BUS_IDLE, st[15:8])
      axw(mbh_pkg::MBH_AXI_CTRL, 32'h1);
      op(mbh_pkg::MBH_KIND_RESET, 8'h00, 8'h00);
      axr(mbh_pkg::MBH_AXI_STATUS, st);
      `CHK("irq reset", 1'b0, st[1])
      axw(mbh_pkg::MBH_AXI_CMD, 32'h10038);
      axw(mbh_pkg::MBH_AXI_CMD, 32'h10038);
      `CHK("busy", mbh_pkg::MBH_RESP_SLVERR, bresp)
      op(kr, 8'h38, 8'h00);
      `CHK("reg reset", 8'h00, st[15:8])
      close_out(0);
   end
endmodule : mbh_test
`default_nettype wire
